// *** rcr_top.sv ***
// Repetition counter and two capture/compare value registers behind AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module rcr_top (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [15:0] timer_counter_value,
	input  wire logic        counter_period_event,
	input  wire logic        channel1_capture_event,
	input  wire logic        channel2_capture_event,
	output logic             channel1_output_signal,
	output logic             channel2_output_signal,
	output logic             period_update_event,
	output logic             interrupt_request
);

	// Write address and data are held until both have arrived.
	logic                   aw_held_q;
	logic [7:0]             aw_addr_q;
	logic                   awready_q;
	logic                   w_held_q;
	logic [31:0]            w_data_q;
	logic [3:0]             w_strb_q;
	logic                   wready_q;
	logic                   bvalid_q;
	logic [1:0]             bresp_q;
	// Read channel state.
	logic                   arready_q;
	logic                   rvalid_q;
	logic [31:0]            rdata_q;
	logic [1:0]             rresp_q;
	// Register contents.
	logic [7:0]             repetition_reload_value;
	logic [7:0]             repetition_down_counter;
	rcr_pkg::rcr_mode_type  mode_q;
	rcr_pkg::rcr_irq_type   irq_status_q;
	rcr_pkg::rcr_irq_type   irq_mask_q;
	logic [15:0]            preload_q [rcr_pkg::CHANNELS];
	logic [15:0]            active_q [rcr_pkg::CHANNELS];
	logic [rcr_pkg::CHANNELS-1:0] compare_q;
	logic                   update_q;
	logic                   irq_q;
	// Combinational helpers.
	logic                   do_write;
	logic                   rd_take;
	logic                   update_now;
	logic [31:0]            rd_data;
	logic                   rd_ok;
	logic                   wr_ok;
	logic [rcr_pkg::CHANNELS-1:0] ch_input;
	logic [rcr_pkg::CHANNELS-1:0] ch_preload;
	logic [rcr_pkg::CHANNELS-1:0] ch_capture;
	logic [rcr_pkg::CHANNELS-1:0] ch_write;
	rcr_pkg::rcr_irq_type   irq_events;

	// Merges a write into a 16-bit register under the two low byte strobes.
	function automatic logic [15:0] merge16(input logic [15:0] old_v,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] v;
		v = old_v;
		if (strb[0]) begin
			v[7:0] = data[7:0];
		end
		if (strb[1]) begin
			v[15:8] = data[15:8];
		end
		return v;
	endfunction

	// True when a byte address selects the given register word.
	function automatic logic hits(input logic [7:0] addr, input logic [7:0] ofs);
		return addr[7:2] == ofs[7:2];
	endfunction

	// Outputs are driven straight from their flip-flops.
	assign s_axi_awready          = awready_q;
	assign s_axi_wready           = wready_q;
	assign s_axi_bvalid           = bvalid_q;
	assign s_axi_bresp            = bresp_q;
	assign s_axi_arready          = arready_q;
	assign s_axi_rvalid           = rvalid_q;
	assign s_axi_rdata            = rdata_q;
	assign s_axi_rresp            = rresp_q;
	assign channel1_output_signal = compare_q[0];
	assign channel2_output_signal = compare_q[1];
	assign period_update_event    = update_q;
	assign interrupt_request      = irq_q;

	// A write is carried out once address and data are both held and no
	// response is still waiting to be taken.
	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign rd_take  = s_axi_arvalid && arready_q;

	// The update event is gated by the repetition down-counter.
	assign update_now = counter_period_event && (repetition_down_counter == 8'h00);

	// Per-channel views of mode, capture strobes and write hits.
	assign ch_input   = {mode_q.ch2_input, mode_q.ch1_input};
	assign ch_preload = {mode_q.ch2_preload, mode_q.ch1_preload};
	assign ch_capture = {channel2_capture_event, channel1_capture_event};
	assign ch_write   = {do_write && hits(aw_addr_q, rcr_pkg::OFS_CHANNEL2_VALUE),
		do_write && hits(aw_addr_q, rcr_pkg::OFS_CHANNEL1_VALUE)};

	// Events that set sticky interrupt flags; captures count only in input mode.
	assign irq_events.update      = update_now;
	assign irq_events.ch1_capture = channel1_capture_event && mode_q.ch1_input;
	assign irq_events.ch2_capture = channel2_capture_event && mode_q.ch2_input;

	// Write address channel; awready is low while an address is held.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			aw_held_q <= 1'b0;
			awready_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
			awready_q <= 1'b1;
		end else if (s_axi_awvalid && awready_q) begin
			aw_held_q <= 1'b1;
			awready_q <= 1'b0;
			aw_addr_q <= s_axi_awaddr;
		end else begin
			awready_q <= !aw_held_q;
		end
	end

	// Write data channel; taken independently of the address.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			w_held_q <= 1'b0;
			wready_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (do_write) begin
			w_held_q <= 1'b0;
			wready_q <= 1'b1;
		end else if (s_axi_wvalid && wready_q) begin
			w_held_q <= 1'b1;
			wready_q <= 1'b0;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else begin
			wready_q <= !w_held_q;
		end
	end

	// Unmapped addresses are refused with SLVERR and change nothing.
	always_comb begin
		wr_ok = hits(aw_addr_q, rcr_pkg::OFS_REPETITION_RELOAD)
			|| hits(aw_addr_q, rcr_pkg::OFS_CHANNEL1_VALUE)
			|| hits(aw_addr_q, rcr_pkg::OFS_CHANNEL2_VALUE)
			|| hits(aw_addr_q, rcr_pkg::OFS_CHANNEL_MODE)
			|| hits(aw_addr_q, rcr_pkg::OFS_IRQ_STATUS)
			|| hits(aw_addr_q, rcr_pkg::OFS_IRQ_MASK);
	end

	// Write response; stands until the master takes it.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= rcr_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_ok ? rcr_pkg::RESP_OKAY : rcr_pkg::RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read data multiplexer; reserved bits read as zero.
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (hits(s_axi_araddr, rcr_pkg::OFS_REPETITION_RELOAD)) begin
			rd_data[7:0] = repetition_reload_value;
		end else if (hits(s_axi_araddr, rcr_pkg::OFS_CHANNEL1_VALUE)) begin
			rd_data[15:0] = preload_q[0];
		end else if (hits(s_axi_araddr, rcr_pkg::OFS_CHANNEL2_VALUE)) begin
			rd_data[15:0] = preload_q[1];
		end else if (hits(s_axi_araddr, rcr_pkg::OFS_CHANNEL_MODE)) begin
			rd_data[3:0] = mode_q;
		end else if (hits(s_axi_araddr, rcr_pkg::OFS_IRQ_STATUS)) begin
			rd_data[2:0] = irq_status_q;
		end else if (hits(s_axi_araddr, rcr_pkg::OFS_IRQ_MASK)) begin
			rd_data[2:0] = irq_mask_q;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Read channel; the data is sampled when the address is taken.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= rcr_pkg::RESP_OKAY;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end else if (rd_take) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_data;
			rresp_q   <= rd_ok ? rcr_pkg::RESP_OKAY : rcr_pkg::RESP_SLVERR;
		end else if (!rvalid_q) begin
			arready_q <= 1'b1;
		end
	end

	// Repetition reload value; only the low byte is stored.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			repetition_reload_value <= rcr_pkg::REPETITION_RESET;
		end else if (do_write && w_strb_q[0]
			&& hits(aw_addr_q, rcr_pkg::OFS_REPETITION_RELOAD)) begin
			repetition_reload_value <= w_data_q[7:0];
		end
	end

	// Repetition down-counter. A new reload value is picked up only when the
	// counter wraps, so software changes never cut a repetition short.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			repetition_down_counter <= rcr_pkg::REPETITION_RESET;
		end else if (update_now) begin
			repetition_down_counter <= repetition_reload_value;
		end else if (counter_period_event) begin
			repetition_down_counter <= repetition_down_counter - 8'h01;
		end
	end

	// Gated update event, one cycle wide per (reload + 1) counter periods.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			update_q <= 1'b0;
		end else begin
			update_q <= update_now;
		end
	end

	// Channel mode register.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			mode_q <= rcr_pkg::MODE_RESET;
		end else if (do_write && w_strb_q[0] && hits(aw_addr_q, rcr_pkg::OFS_CHANNEL_MODE)) begin
			mode_q <= w_data_q[3:0];
		end
	end

	// Interrupt mask register.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_mask_q <= rcr_pkg::IRQ_RESET;
		end else if (do_write && w_strb_q[0] && hits(aw_addr_q, rcr_pkg::OFS_IRQ_MASK)) begin
			irq_mask_q <= w_data_q[2:0];
		end
	end

	// Sticky status, cleared by reading it; an event in the clearing cycle
	// is kept, so no update or capture is ever lost to a read.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_status_q <= rcr_pkg::IRQ_RESET;
		end else if (rd_take && hits(s_axi_araddr, rcr_pkg::OFS_IRQ_STATUS)) begin
			irq_status_q <= irq_events;
		end else begin
			irq_status_q <= irq_status_q | irq_events;
		end
	end

	// Level interrupt; lags the status by one cycle so it leaves a flop.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_status_q & irq_mask_q);
		end
	end

	// Default clock and reset for every assertion in this module.
	default clocking dflt_cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Both channels share one structure; index 0 is channel 1.
	for (genvar i = 0; i < rcr_pkg::CHANNELS; i++) begin : g_chan

		// Preload register: software writes in output mode, captures in input
		// mode. Writes in input mode are dropped, yet still answered OKAY.
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				preload_q[i] <= rcr_pkg::VALUE_RESET;
			end else if (ch_input[i]) begin
				if (ch_capture[i]) begin
					preload_q[i] <= timer_counter_value;
				end
			end else if (ch_write[i]) begin
				preload_q[i] <= merge16(preload_q[i], w_data_q, w_strb_q);
			end
		end

		// Active compare register: direct write without preload, transfer at
		// the gated update with preload. A write and an update in one cycle
		// transfer the value held before the write.
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				active_q[i] <= rcr_pkg::VALUE_RESET;
			end else if (!ch_input[i]) begin
				if (!ch_preload[i] && ch_write[i]) begin
					active_q[i] <= merge16(preload_q[i], w_data_q, w_strb_q);
				end else if (ch_preload[i] && update_now) begin
					active_q[i] <= preload_q[i];
				end
			end
		end

		// Compare result: high while the counter is below the active value.
		always_ff @(posedge clk_sys) begin
			if (!rst_n) begin
				compare_q[i] <= 1'b0;
			end else begin
				compare_q[i] <= timer_counter_value < active_q[i];
			end
		end

		direct_write_a: assert property (
			ch_write[i] && !ch_input[i] && !ch_preload[i] && w_strb_q[1:0] == 2'h3
			|=> active_q[i] == $past(w_data_q[15:0]))
			else $error("direct compare write not applied");

		preload_transfer_a: assert property (
			update_now && ch_preload[i] && !ch_input[i]
			|=> active_q[i] == $past(preload_q[i]))
			else $error("preload not moved on update");

		preload_hold_a: assert property (
			ch_preload[i] && !update_now |=> $stable(active_q[i]))
			else $error("active value moved without update");

		compare_out_a: assert property (
			##1 compare_q[i] == $past(timer_counter_value < active_q[i]))
			else $error("compare output wrong");

		capture_load_a: assert property (
			ch_input[i] && ch_capture[i]
			|=> preload_q[i] == $past(timer_counter_value))
			else $error("capture value not loaded");

		input_ro_a: assert property (
			ch_input[i] && !ch_capture[i] |=> $stable(preload_q[i]))
			else $error("input mode value changed by write");
	end

	reload_store_a: assert property (
		do_write && w_strb_q[0] && hits(aw_addr_q, rcr_pkg::OFS_REPETITION_RELOAD)
		|=> repetition_reload_value == $past(w_data_q[7:0]))
		else $error("repetition reload not stored");

	zero_update_a: assert property (
		update_now |=> period_update_event
		&& repetition_down_counter == $past(repetition_reload_value))
		else $error("no update or reload at zero");

	reload_only_a: assert property (
		!counter_period_event |=> $stable(repetition_down_counter) && !period_update_event)
		else $error("down-counter moved without period");

	count_down_a: assert property (
		counter_period_event && repetition_down_counter != 8'h00
		|=> !period_update_event
		&& repetition_down_counter == $past(repetition_down_counter) - 8'h01)
		else $error("update outside repetition boundary");

	// The mask must still be set one cycle later, since the level output is
	// formed from the status and the mask of that cycle.
	update_irq_a: assert property (
		(update_now && irq_mask_q.update) ##1 irq_mask_q.update
		|-> irq_status_q.update ##1 interrupt_request)
		else $error("update interrupt not raised");

	cover_update_c: cover property (update_now ##1 period_update_event);
	cover_capture_c: cover property (mode_q.ch1_input && channel1_capture_event);
	cover_irq_c: cover property (!interrupt_request ##1 interrupt_request);
	cover_write_c: cover property (s_axi_bvalid && s_axi_bready);

endmodule

`default_nettype wire

// *** rcr_pkg.sv ***
// Shared constants and types for the repetition and compare register block.
package rcr_pkg;

	// Byte addresses of the registers on the AXI4-Lite slave.
	localparam logic [7:0] OFS_REPETITION_RELOAD = 8'h30;
	localparam logic [7:0] OFS_CHANNEL1_VALUE    = 8'h34;
	localparam logic [7:0] OFS_CHANNEL2_VALUE    = 8'h38;
	localparam logic [7:0] OFS_CHANNEL_MODE      = 8'h3C;
	localparam logic [7:0] OFS_IRQ_STATUS        = 8'h40;
	localparam logic [7:0] OFS_IRQ_MASK          = 8'h48;

	// Values taken by the registers after reset.
	localparam logic [7:0]  REPETITION_RESET = 8'h00;
	localparam logic [15:0] VALUE_RESET      = 16'h0000;
	localparam logic [3:0]  MODE_RESET       = 4'h0;
	localparam logic [2:0]  IRQ_RESET        = 3'h0;

	// Field positions inside the channel mode register.
	localparam int MODE_CH1_INPUT   = 0;
	localparam int MODE_CH1_PRELOAD = 1;
	localparam int MODE_CH2_INPUT   = 2;
	localparam int MODE_CH2_PRELOAD = 3;

	// Field positions inside the interrupt status and mask registers.
	localparam int IRQ_UPDATE       = 0;
	localparam int IRQ_CH1_CAPTURE  = 1;
	localparam int IRQ_CH2_CAPTURE  = 2;

	// Number of capture/compare channels.
	localparam int CHANNELS = 2;

	// AXI4-Lite response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Channel mode bits, laid out as in the mode register.
	typedef struct packed {
		logic ch2_preload;
		logic ch2_input;
		logic ch1_preload;
		logic ch1_input;
	} rcr_mode_type;

	// Sticky interrupt flags, laid out as in the status register.
	typedef struct packed {
		logic ch2_capture;
		logic ch1_capture;
		logic update;
	} rcr_irq_type;

endpackage

// *** tb_rcr_top.sv ***
// Self-checking testbench for the repetition and compare register block.
`timescale 1ns/100ps
`default_nettype none

module tb_rcr_top;
	logic        clk_sys;
	logic        rst_n;
	logic [7:0]  s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [7:0]  s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [15:0] timer_counter_value;
	logic        counter_period_event;
	logic        channel1_capture_event;
	logic        channel2_capture_event;
	logic        channel1_output_signal;
	logic        channel2_output_signal;
	logic        period_update_event;
	logic        interrupt_request;
	int          bad_count;              // Mismatches seen so far.
	int          compares;               // Comparisons made so far.

	rcr_top u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .timer_counter_value(timer_counter_value),
		.counter_period_event(counter_period_event),
		.channel1_capture_event(channel1_capture_event),
		.channel2_capture_event(channel2_capture_event),
		.channel1_output_signal(channel1_output_signal),
		.channel2_output_signal(channel2_output_signal),
		.period_update_event(period_update_event),
		.interrupt_request(interrupt_request)
	);

	// The clock toggles every half period of 2.5 ns.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("Counts: %0d comparisons, %0d mismatches", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one and counts the outcome.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares = compares + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// A wait that runs out of cycles is a failure, so the run stops at once.
	task automatic timed_out();
		bad_count = bad_count + 1;
		$display("wrong value at %0t: handshake never completed", $time);
		results();
	endtask

	// One write; address and data are offered together and each is dropped once taken.
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 50) begin
			timed_out();
		end
	endtask

	// One read; rready stays high until the data is sampled.
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 50) begin
			timed_out();
		end
	endtask

	// Reads a register and compares the word; the response must be OKAY.
	task automatic expect_read(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(a, d, r);
		check({30'h0, r}, {30'h0, rcr_pkg::RESP_OKAY}, "read response");
		check(d, exp, "read data");
	endtask

	// One counter period event; returns whether it became an update event.
	task automatic period_pulse(output logic upd);
		@(posedge clk_sys);
		counter_period_event <= 1'b1;
		@(posedge clk_sys);
		counter_period_event <= 1'b0;
		@(posedge clk_sys);
		upd = period_update_event;
	endtask

	// A capture strobe on one channel while the counter shows the given value.
	task automatic capture(input int ch, input logic [15:0] value);
		@(posedge clk_sys);
		timer_counter_value <= value;
		channel1_capture_event <= (ch == 1);
		channel2_capture_event <= (ch == 2);
		@(posedge clk_sys);
		channel1_capture_event <= 1'b0;
		channel2_capture_event <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Reset values, the reserved upper three bytes and an unmapped address.
	task automatic s_reset_map();
		logic [31:0] d;
		logic [1:0]  r;
		expect_read(rcr_pkg::OFS_REPETITION_RELOAD, 32'h0000_0000);
		expect_read(rcr_pkg::OFS_CHANNEL1_VALUE, 32'h0000_0000);
		expect_read(rcr_pkg::OFS_CHANNEL2_VALUE, 32'h0000_0000);
		axi_write(rcr_pkg::OFS_REPETITION_RELOAD, 32'hFFFF_FF01, r);
		expect_read(rcr_pkg::OFS_REPETITION_RELOAD, 32'h0000_0001);
		axi_write(8'h20, 32'h0000_1234, r);
		check({30'h0, r}, {30'h0, rcr_pkg::RESP_SLVERR}, "unmapped write");
		axi_read(8'h20, d, r);
		check({30'h0, r}, {30'h0, rcr_pkg::RESP_SLVERR}, "unmapped read");
		check(d, 32'h0000_0000, "unmapped data");
	endtask

	// Reload 1 gives an update every second period; a new reload waits for an update.
	task automatic s_repetition();
		logic        upd;
		logic [1:0]  r;
		logic [9:0]  pattern;
		pattern = 10'h255;
		for (int i = 0; i < 10; i++) begin
			if (i == 5) begin
				axi_write(rcr_pkg::OFS_REPETITION_RELOAD, 32'h0000_0002, r);
			end
			period_pulse(upd);
			check({31'h0, upd}, {31'h0, pattern[i]}, "update event");
		end
		check({31'h0, interrupt_request}, 32'h0, "masked interrupt");
	endtask

	// Unmasked update interrupt, raised once per gated update and cleared by a read.
	task automatic s_interrupt();
		logic        upd;
		logic [1:0]  r;
		expect_read(rcr_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
		axi_write(rcr_pkg::OFS_IRQ_MASK, 32'h0000_0001, r);
		for (int i = 0; i < 3; i++) begin
			period_pulse(upd);
			check({31'h0, upd}, {31'h0, i == 2}, "update after reload 2");
		end
		@(posedge clk_sys);
		check({31'h0, interrupt_request}, 32'h1, "interrupt raised");
		expect_read(rcr_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		check({31'h0, interrupt_request}, 32'h0, "interrupt cleared");
	endtask

	// Direct writes reach the comparators, then preloaded values wait for an update.
	task automatic s_compare();
		logic        upd;
		logic [1:0]  r;
		axi_write(rcr_pkg::OFS_CHANNEL_MODE, 32'h0000_0000, r);
		timer_counter_value <= 16'h0100;
		axi_write(rcr_pkg::OFS_CHANNEL1_VALUE, 32'h0000_0080, r);
		axi_write(rcr_pkg::OFS_CHANNEL2_VALUE, 32'h0000_0300, r);
		repeat (3) @(posedge clk_sys);
		check({31'h0, channel1_output_signal}, 32'h0, "ch1 direct");
		check({31'h0, channel2_output_signal}, 32'h1, "ch2 direct");
		axi_write(rcr_pkg::OFS_CHANNEL_MODE, 32'h0000_000A, r);
		axi_write(rcr_pkg::OFS_CHANNEL1_VALUE, 32'h0000_0200, r);
		axi_write(rcr_pkg::OFS_CHANNEL2_VALUE, 32'h0000_0050, r);
		period_pulse(upd);
		period_pulse(upd);
		repeat (2) @(posedge clk_sys);
		check({31'h0, channel1_output_signal}, 32'h0, "ch1 held");
		check({31'h0, channel2_output_signal}, 32'h1, "ch2 held");
		period_pulse(upd);
		check({31'h0, upd}, 32'h1, "transfer update");
		repeat (2) @(posedge clk_sys);
		check({31'h0, channel1_output_signal}, 32'h1, "ch1 moved");
		check({31'h0, channel2_output_signal}, 32'h0, "ch2 moved");
		expect_read(rcr_pkg::OFS_CHANNEL1_VALUE, 32'h0000_0200);
	endtask

	// Input mode holds the last captured count and ignores software writes.
	task automatic s_capture();
		logic [1:0] r;
		axi_write(rcr_pkg::OFS_CHANNEL_MODE, 32'h0000_0005, r);
		capture(1, 16'h1234);
		capture(2, 16'h0ABC);
		expect_read(rcr_pkg::OFS_CHANNEL1_VALUE, 32'h0000_1234);
		expect_read(rcr_pkg::OFS_CHANNEL2_VALUE, 32'h0000_0ABC);
		axi_write(rcr_pkg::OFS_CHANNEL1_VALUE, 32'h0000_5555, r);
		check({30'h0, r}, {30'h0, rcr_pkg::RESP_OKAY}, "ignored write");
		expect_read(rcr_pkg::OFS_CHANNEL1_VALUE, 32'h0000_1234);
		capture(1, 16'h4321);
		expect_read(rcr_pkg::OFS_CHANNEL1_VALUE, 32'h0000_4321);
		expect_read(rcr_pkg::OFS_CHANNEL_MODE, 32'h0000_0005);
		expect_read(rcr_pkg::OFS_IRQ_MASK, 32'h0000_0001);
		expect_read(rcr_pkg::OFS_IRQ_STATUS, 32'h0000_0007);
	endtask

	// Main sequence: quiet inputs, three cycles of reset, then each scenario.
	initial begin
		bad_count = 0;
		compares = 0;
		rst_n = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		timer_counter_value = 16'h0000;
		counter_period_event = 1'b0;
		channel1_capture_event = 1'b0;
		channel2_capture_event = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		s_reset_map();
		s_repetition();
		s_interrupt();
		s_compare();
		s_capture();
		results();
	end
endmodule

`default_nettype wire
